// ---- irqc_pkg.sv ----
// Constants shared by the interrupt controller and its stack memory.
// Assumes an 8-bit register port with a 3-bit word address.
package irqc_pkg;

  // ==========================================================================
  // Source counts and register port
  localparam int NUM_EXT = 4;
  localparam int NUM_CMP = 2;
  localparam int NUM_MF  = 6;
  localparam int NUM_SRC = NUM_EXT + NUM_CMP + NUM_MF;
  localparam int IDX_W   = 4;
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_ENABLES  = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_MF_FLAGS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_MF_EN    = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_T3_CTRL  = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h7;

  // ==========================================================================
  // Field positions
  localparam int CTRL_GIE_BIT  = 0;
  localparam int EXT_LSB       = 0;
  localparam int CMP_LSB       = 4;
  localparam int T3_AF_BIT     = 5;
  localparam int T3_PF_BIT     = 4;
  localparam int T3_AE_BIT     = 1;
  localparam int T3_PE_BIT     = 0;
  localparam int STAT_FULL_BIT = 6;
  localparam int STAT_PEND_BIT = 7;
  localparam int STAT_SP_MAX_W = 6;
  // Shared interrupt that groups the timer-3 match sources
  localparam int T3_MF_IDX     = 3;

  // ==========================================================================
  // Edge select codes, two bits per pin
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================================
  // Vector table: source n jumps to VEC_BASE + n * VEC_STEP
  localparam int VEC_BASE = 4;
  localparam int VEC_STEP = 4;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_POP  = 1'h1
  } ctl_state_t;

endpackage

// ---- irqc_stack_mem.sv ----
// Return-address stack storage for the interrupt controller.
// Assumes one write and one read per cycle; read data are registered.
`timescale 1ns/10ps
module irqc_stack_mem
  import irqc_pkg::*;
#(
  parameter int DW    = 13,
  parameter int DEPTH = 8,
  parameter int AW    = 3
)
(
  input  wire logic          CLOCK_I,
  input  wire logic          SYS_RST_I,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } mem_state_t;

  mem_state_t s_reg;
  mem_state_t s_next;

  if (DEPTH > (1 << AW))
    $error("stack depth exceeds address range");

  // ==========================================================================
  // Storage
  always_comb
  begin
    s_next = s_reg;
    if (we_i)
    begin
      s_next.mem[waddr_i] = wdata_i;
    end
    s_next.rdata = s_reg.mem[raddr_i];
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rdata_o = s_reg.rdata;

endmodule

// ---- irq_controller.sv ----
// Interrupt controller with flags, enables, priority, vectoring and stack.
// Assumes the core raises BOUNDARY_I between instructions and takes
// PC_LOAD_O/PC_TARGET_O as its next fetch address.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module irq_controller
  import irqc_pkg::*;
#(
  parameter int PC_W        = 13,
  parameter int STACK_DEPTH = 8
)
(
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RDATA_O,
  input  wire logic [NUM_EXT-1:0] EXT_PIN_I,
  input  wire logic [NUM_CMP-1:0] CMP_OUT_I,
  input  wire logic              TMR3_CMPA_MATCH_I,
  input  wire logic              TMR3_CMPP_MATCH_I,
  input  wire logic [NUM_MF-1:0] MF_SUB_REQ_I,
  input  wire logic [PC_W-1:0]   PC_NEXT_I,
  input  wire logic              BOUNDARY_I,
  input  wire logic              CORE_PUSH_I,
  input  wire logic              CORE_POP_I,
  output logic                   PC_LOAD_O,
  output logic      [PC_W-1:0]   PC_TARGET_O,
  output logic                   IRQ_TAKEN_O,
  output logic      [IDX_W-1:0]  IRQ_INDEX_O,
  output logic                   STACK_FULL_O,
  output logic                   WAKE_O,
  output logic                   GLOBAL_IRQ_EN_O
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int AW   = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  if (STACK_DEPTH < 2 || SP_W > STAT_SP_MAX_W || PC_W < IDX_W + 2)
    $error("unsupported stack depth or program counter width");

  typedef struct packed {
    logic                   gie;
    logic [NUM_EXT-1:0]     ext_flag;
    logic [NUM_EXT-1:0]     ext_en;
    logic [NUM_CMP-1:0]     cmp_flag;
    logic [NUM_CMP-1:0]     cmp_en;
    logic [NUM_MF-1:0]      mf_flag;
    logic [NUM_MF-1:0]      mf_en;
    logic [2*NUM_EXT-1:0]   edge_sel;
    logic [1:0]             t3_flag;
    logic [1:0]             t3_en;
    logic [NUM_EXT-1:0]     pin_prev;
    logic [NUM_CMP-1:0]     cmp_prev;
    logic                   prev_valid;
    logic [SP_W-1:0]        sp;
    ctl_state_t             st;
    logic                   pc_load;
    logic [PC_W-1:0]        pc_target;
    logic                   taken;
    logic [IDX_W-1:0]       taken_idx;
    logic [DATA_W-1:0]      rdata;
    logic                   wake;
    logic                   full;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_CMP-1:0] cmp_hit;
  logic [1:0]         t3_hit;
  logic [NUM_MF-1:0]  mf_hit;
  logic [NUM_SRC-1:0] req_vec;
  logic [NUM_SRC-1:0] svc_mask;
  logic [IDX_W-1:0]   win_idx;
  logic               pend;
  logic               full;
  logic               take;
  logic               push;
  logic               pop;
  logic [PC_W-1:0]    vec_addr;
  logic [PC_W-1:0]    mem_rdata;

  // ==========================================================================
  // Source detection
  // Edges are ignored on the first cycle after reset so that a pin already
  // high is not mistaken for a rising edge.
  for (genvar i = 0; i < NUM_EXT; i++)
  begin : g_ext
    logic [1:0] sel;
    logic       rise;
    logic       fall;
    assign sel  = s_reg.edge_sel[2*i +: 2];
    assign rise = EXT_PIN_I[i] & ~s_reg.pin_prev[i];
    assign fall = ~EXT_PIN_I[i] & s_reg.pin_prev[i];
    assign ext_hit[i] = s_reg.prev_valid &
                        (((sel == EDGE_RISE) & rise) |
                         ((sel == EDGE_FALL) & fall) |
                         ((sel == EDGE_BOTH) & (rise | fall)));
  end

  assign cmp_hit = {NUM_CMP{s_reg.prev_valid}} & (CMP_OUT_I ^ s_reg.cmp_prev);
  assign t3_hit  = {TMR3_CMPA_MATCH_I, TMR3_CMPP_MATCH_I};

  always_comb
  begin
    mf_hit = MF_SUB_REQ_I;
    mf_hit[T3_MF_IDX] = MF_SUB_REQ_I[T3_MF_IDX] | (|t3_hit);
  end

  // ==========================================================================
  // Arbitration and stack control
  assign req_vec = {s_reg.mf_flag & s_reg.mf_en,
                    s_reg.cmp_flag & s_reg.cmp_en,
                    s_reg.ext_flag & s_reg.ext_en};
  assign pend = |req_vec;
  assign full = (s_reg.sp == SP_FULL);

  // Lowest index wins: pins, then comparators, then shared interrupts
  always_comb
  begin
    win_idx = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--)
    begin
      if (req_vec[k])
        win_idx = IDX_W'(k);
    end
  end

  // Core stack traffic has precedence; an interrupt waits for a quiet slot
  assign take = s_reg.gie & pend & BOUNDARY_I & ~full
              & ~CORE_PUSH_I & ~CORE_POP_I & (s_reg.st == ST_IDLE);
  assign push = take | (CORE_PUSH_I & ~full);
  assign pop  = CORE_POP_I & (s_reg.sp != '0) & (s_reg.st == ST_IDLE);
  assign svc_mask = take ? (NUM_SRC'(1) << win_idx) : '0;
  assign vec_addr = PC_W'(VEC_BASE) + PC_W'(win_idx) * PC_W'(VEC_STEP);

  irqc_stack_mem #(
    .DW    (PC_W),
    .DEPTH (STACK_DEPTH),
    .AW    (AW)
  ) u_stack (
    .CLOCK_I   (CLOCK_I),
    .SYS_RST_I (SYS_RST_I),
    .we_i      (push),
    .waddr_i   (s_reg.sp[AW-1:0]),
    .wdata_i   (PC_NEXT_I),
    .raddr_i   (AW'(s_reg.sp - SP_W'(1))),
    .rdata_o   (mem_rdata)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.pin_prev   = EXT_PIN_I;
    s_next.cmp_prev   = CMP_OUT_I;
    s_next.prev_valid = 1'b1;

    // A hardware set in the same cycle beats both service and write clears
    s_next.ext_flag = ext_hit | ((WR_I && ADDR_I == OFS_FLAGS) ?
                      WDATA_I[EXT_LSB +: NUM_EXT] :
                      (s_reg.ext_flag & ~svc_mask[NUM_EXT-1:0]));
    s_next.cmp_flag = cmp_hit | ((WR_I && ADDR_I == OFS_FLAGS) ?
                      WDATA_I[CMP_LSB +: NUM_CMP] :
                      (s_reg.cmp_flag & ~svc_mask[NUM_EXT +: NUM_CMP]));
    s_next.mf_flag  = mf_hit | ((WR_I && ADDR_I == OFS_MF_FLAGS) ?
                      WDATA_I[NUM_MF-1:0] :
                      (s_reg.mf_flag & ~svc_mask[NUM_EXT+NUM_CMP +: NUM_MF]));
    // Sub-source flags are never cleared by service
    s_next.t3_flag  = t3_hit | ((WR_I && ADDR_I == OFS_T3_CTRL) ?
                      {WDATA_I[T3_AF_BIT], WDATA_I[T3_PF_BIT]} : s_reg.t3_flag);

    if (WR_I)
    begin
      unique case (ADDR_I)
        OFS_ENABLES:
        begin
          s_next.ext_en = WDATA_I[EXT_LSB +: NUM_EXT];
          s_next.cmp_en = WDATA_I[CMP_LSB +: NUM_CMP];
        end
        OFS_MF_EN:    s_next.mf_en = WDATA_I[NUM_MF-1:0];
        OFS_EDGE_SEL: s_next.edge_sel = WDATA_I;
        OFS_T3_CTRL:  s_next.t3_en = {WDATA_I[T3_AE_BIT], WDATA_I[T3_PE_BIT]};
        OFS_CTRL:     s_next.gie = WDATA_I[CTRL_GIE_BIT];
        default:      s_next.t3_en = s_reg.t3_en;
      endcase
    end
    // Entry clears the global enable even against a same-cycle write
    if (take)
      s_next.gie = 1'b0;

    s_next.rdata = '0;
    if (RD_I)
    begin
      unique case (ADDR_I)
        OFS_CTRL:     s_next.rdata[CTRL_GIE_BIT] = s_reg.gie;
        OFS_FLAGS:
        begin
          s_next.rdata[EXT_LSB +: NUM_EXT] = s_reg.ext_flag;
          s_next.rdata[CMP_LSB +: NUM_CMP] = s_reg.cmp_flag;
        end
        OFS_ENABLES:
        begin
          s_next.rdata[EXT_LSB +: NUM_EXT] = s_reg.ext_en;
          s_next.rdata[CMP_LSB +: NUM_CMP] = s_reg.cmp_en;
        end
        OFS_MF_FLAGS: s_next.rdata[NUM_MF-1:0] = s_reg.mf_flag;
        OFS_MF_EN:    s_next.rdata[NUM_MF-1:0] = s_reg.mf_en;
        OFS_EDGE_SEL: s_next.rdata = s_reg.edge_sel;
        OFS_T3_CTRL:
        begin
          // Unused bits stay at their cleared value
          s_next.rdata[T3_AF_BIT] = s_reg.t3_flag[1];
          s_next.rdata[T3_PF_BIT] = s_reg.t3_flag[0];
          s_next.rdata[T3_AE_BIT] = s_reg.t3_en[1];
          s_next.rdata[T3_PE_BIT] = s_reg.t3_en[0];
        end
        OFS_STATUS:
        begin
          s_next.rdata[SP_W-1:0]     = s_reg.sp;
          s_next.rdata[STAT_FULL_BIT] = full;
          s_next.rdata[STAT_PEND_BIT] = pend;
        end
      endcase
    end

    if (push)
      s_next.sp = s_reg.sp + SP_W'(1);
    else if (pop)
      s_next.sp = s_reg.sp - SP_W'(1);

    s_next.pc_load   = take;
    s_next.pc_target = vec_addr;
    s_next.taken     = take;
    s_next.taken_idx = win_idx;
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (pop)
          s_next.st = ST_POP;
      end
      ST_POP:
      begin
        // Read data of the popped entry arrive one cycle after the pop
        s_next.pc_load   = 1'b1;
        s_next.pc_target = mem_rdata;
        s_next.st        = ST_IDLE;
      end
    endcase

    s_next.full = (s_next.sp == SP_FULL);
    s_next.wake = |{s_next.ext_flag, s_next.cmp_flag, s_next.mf_flag,
                    s_next.t3_flag};
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign RDATA_O         = s_reg.rdata;
  assign PC_LOAD_O       = s_reg.pc_load;
  assign PC_TARGET_O     = s_reg.pc_target;
  assign IRQ_TAKEN_O     = s_reg.taken;
  assign IRQ_INDEX_O     = s_reg.taken_idx;
  assign STACK_FULL_O    = s_reg.full;
  assign WAKE_O          = s_reg.wake;
  assign GLOBAL_IRQ_EN_O = s_reg.gie;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_pop_req;
    CORE_POP_I && !STACK_FULL_O && (s_reg.sp != '0) && (s_reg.st == ST_IDLE);
  endsequence
  sequence s_pc_reload;
    PC_LOAD_O && !IRQ_TAKEN_O;
  endsequence
  property p_t3_reserved;
    RD_I && ADDR_I == OFS_T3_CTRL |=> RDATA_O[7:6] == 2'h0 && RDATA_O[3:2] == 2'h0;
  endproperty
  a_t3_reserved: assert property (p_t3_reserved)
    else $error("reserved timer-3 bits read nonzero");
  property p_t3_set;
    TMR3_CMPA_MATCH_I |=> s_reg.t3_flag[1] && s_reg.mf_flag[T3_MF_IDX];
  endproperty
  a_t3_set: assert property (p_t3_set)
    else $error("timer-3 match did not set its flags");
  property p_gie_blocks;
    !GLOBAL_IRQ_EN_O |=> !IRQ_TAKEN_O;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("interrupt taken with global enable low");
  property p_no_nest;
    IRQ_TAKEN_O |-> !GLOBAL_IRQ_EN_O && PC_LOAD_O;
  endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("global enable not cleared on entry");
  property p_full_blocks;
    STACK_FULL_O |=> !IRQ_TAKEN_O;
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("interrupt taken with stack full");
  property p_vector;
    IRQ_TAKEN_O |-> PC_TARGET_O ==
      PC_W'(VEC_BASE) + PC_W'(IRQ_INDEX_O) * PC_W'(VEC_STEP);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector address does not match source");
  property p_return;
    s_pop_req |=> !PC_LOAD_O ##1 s_pc_reload;
  endproperty
  a_return: assert property (p_return)
    else $error("return did not reload program counter");
  // The request vector is sampled a cycle back, the index is the current one
  property p_enabled_only;
    IRQ_TAKEN_O |-> |($past(req_vec) & (NUM_SRC'(1) << IRQ_INDEX_O));
  endproperty
  a_enabled_only: assert property (p_enabled_only)
    else $error("disabled source was serviced");
  property p_wake;
    (|ext_hit) |=> WAKE_O;
  endproperty
  a_wake: assert property (p_wake)
    else $error("flag set without wake");
  property p_shared_keep;
    take && win_idx == IDX_W'(NUM_EXT + NUM_CMP + T3_MF_IDX) && !WR_I
      |=> s_reg.t3_flag == ($past(s_reg.t3_flag) | $past(t3_hit));
  endproperty
  a_shared_keep: assert property (p_shared_keep)
    else $error("sub-source flag changed on shared service");

endmodule

// ---- irqc_core_model.sv ----
// Behavioural processor core that faces the interrupt controller.
// Assumes the bench commands returns and calls one cycle at a time and may hold a stall for many cycles.
`timescale 1ns/10ps
module irqc_core_model
  import irqc_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input  wire logic            CLOCK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic            load_i,
  input  wire logic [PC_W-1:0] target_i,
  input  wire logic            taken_i,
  input  wire logic            ret_i,
  input  wire logic            call_i,
  input  wire logic            stall_i,
  output logic      [PC_W-1:0] pc_next_o,
  output logic                 boundary_o,
  output logic                 pop_o,
  output logic                 push_o,
  output logic      [PC_W-1:0] saved_o
);
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] prev_reg;

  // ==========================================================================
  // Sequencer
  // A stalled core or one busy with a call or return is never at a boundary
  assign boundary_o = ~stall_i & ~ret_i & ~call_i;
  assign pop_o      = ret_i;
  assign push_o     = call_i;
  assign pc_next_o  = pc_reg;

  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      pc_reg   <= '0;
      prev_reg <= '0;
      saved_o  <= '0;
    end
    else
    begin
      prev_reg <= pc_reg;
      if (load_i)
        pc_reg <= target_i;
      else
        pc_reg <= pc_reg + 1'b1;
      // The pushed address is the one offered in the cycle before the pulse
      if (taken_i)
        saved_o <= prev_reg;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the interrupt controller.
// Assumes the design ports of irq_controller and the core model beside it.
`timescale 1ns/10ps
module tb_top
  import irqc_pkg::*;
;
  localparam int DEPTH = 8;
  typedef struct packed {
    logic [3:0] idx;
    logic [1:0] mode;
    logic       lvl0;
    logic       lvl1;
    logic       fire;
  } row_t;

  logic               CLOCK_I = 1'h0;
  logic               SYS_RST_I = 1'h1;
  logic [ADDR_W-1:0]  ADDR_I = '0;
  logic [DATA_W-1:0]  WDATA_I = '0;
  logic               WR_I = 1'h0;
  logic               RD_I = 1'h0;
  logic [DATA_W-1:0]  RDATA_O;
  logic [NUM_EXT-1:0] EXT_PIN_I = '0;
  logic [NUM_CMP-1:0] CMP_OUT_I = '0;
  logic               TMR3_CMPA_MATCH_I = 1'h0;
  logic               TMR3_CMPP_MATCH_I = 1'h0;
  logic [NUM_MF-1:0]  MF_SUB_REQ_I = '0;
  logic [12:0]        PC_NEXT_I, PC_TARGET_O, saved;
  logic               BOUNDARY_I, CORE_PUSH_I, CORE_POP_I, PC_LOAD_O, IRQ_TAKEN_O;
  logic [IDX_W-1:0]   IRQ_INDEX_O;
  logic               STACK_FULL_O, WAKE_O, GLOBAL_IRQ_EN_O;
  logic               ret = 1'h0;
  logic               call = 1'h0;
  logic               stall = 1'h0;
  int                 errors = 0;
  int                 n_checks = 0;
  int                 cycles = 0;

  row_t rows [11] = '{
    '{4'h0, EDGE_RISE, 1'h0, 1'h1, 1'h1}, '{4'h1, EDGE_FALL, 1'h1, 1'h0, 1'h1},
    '{4'h2, EDGE_BOTH, 1'h1, 1'h0, 1'h1}, '{4'h3, EDGE_BOTH, 1'h0, 1'h1, 1'h1},
    '{4'h0, EDGE_RISE, 1'h1, 1'h0, 1'h0}, '{4'h1, EDGE_OFF, 1'h0, 1'h1, 1'h0},
    '{4'h2, EDGE_FALL, 1'h0, 1'h1, 1'h0}, '{4'h4, EDGE_OFF, 1'h0, 1'h1, 1'h1},
    '{4'h5, EDGE_OFF, 1'h1, 1'h0, 1'h1}, '{4'h6, EDGE_OFF, 1'h0, 1'h0, 1'h1},
    '{4'hB, EDGE_OFF, 1'h0, 1'h0, 1'h1}};

  irq_controller #(.PC_W(13), .STACK_DEPTH(DEPTH)) uut (
    .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .EXT_PIN_I(EXT_PIN_I),
    .CMP_OUT_I(CMP_OUT_I), .TMR3_CMPA_MATCH_I(TMR3_CMPA_MATCH_I),
    .TMR3_CMPP_MATCH_I(TMR3_CMPP_MATCH_I), .MF_SUB_REQ_I(MF_SUB_REQ_I),
    .PC_NEXT_I(PC_NEXT_I), .BOUNDARY_I(BOUNDARY_I), .CORE_PUSH_I(CORE_PUSH_I),
    .CORE_POP_I(CORE_POP_I), .PC_LOAD_O(PC_LOAD_O), .PC_TARGET_O(PC_TARGET_O),
    .IRQ_TAKEN_O(IRQ_TAKEN_O), .IRQ_INDEX_O(IRQ_INDEX_O), .STACK_FULL_O(STACK_FULL_O),
    .WAKE_O(WAKE_O), .GLOBAL_IRQ_EN_O(GLOBAL_IRQ_EN_O));

  irqc_core_model #(.PC_W(13)) core (
    .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .load_i(PC_LOAD_O), .target_i(PC_TARGET_O),
    .taken_i(IRQ_TAKEN_O), .ret_i(ret), .call_i(call), .stall_i(stall),
    .pc_next_o(PC_NEXT_I), .boundary_o(BOUNDARY_I), .pop_o(CORE_POP_I),
    .push_o(CORE_PUSH_I), .saved_o(saved));

  // ==========================================================================
  // Clock, timeout and shared tasks
  initial
  begin
    forever #25 CLOCK_I = ~CLOCK_I;
  end

  always @(posedge CLOCK_I)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLOCK_I);
    WR_I    <= 1'h1;
    ADDR_I  <= a;
    WDATA_I <= d;
    @(posedge CLOCK_I);
    WR_I <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge CLOCK_I);
    RD_I   <= 1'h1;
    ADDR_I <= a;
    @(posedge CLOCK_I);
    RD_I <= 1'h0;
    #1;
    chk("rdata", RDATA_O, exp);
  endtask

  // Bounded wait for an entry; a refused entry must stay absent for the whole wait
  task automatic wait_irq(input logic fire, input logic [3:0] idx);
    int n;
    n = 0;
    #1;
    while (IRQ_TAKEN_O !== 1'h1 && n < 12)
    begin
      @(posedge CLOCK_I);
      #1;
      n++;
    end
    chk("taken", IRQ_TAKEN_O, fire);
    if (fire)
    begin
      chk("index", IRQ_INDEX_O, idx);
      chk("vector", PC_TARGET_O, 16'(VEC_BASE + VEC_STEP * idx));
      chk("gie", GLOBAL_IRQ_EN_O, 1'h0);
      chk("load", PC_LOAD_O, 1'h1);
    end
  endtask

  task automatic do_ret();
    @(posedge CLOCK_I);
    ret <= 1'h1;
    @(posedge CLOCK_I);
    ret <= 1'h0;
    @(posedge CLOCK_I);
    #1;
    chk("ret_load", PC_LOAD_O, 1'h1);
    chk("ret_pc", PC_TARGET_O, saved);
    chk("ret_taken", IRQ_TAKEN_O, 1'h0);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [15:0] en;
    repeat (8) @(posedge CLOCK_I);
    SYS_RST_I <= 1'h0;
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h00);
    foreach (rows[r])
    begin
      en = 16'h0001 << rows[r].idx;
      EXT_PIN_I <= {4{rows[r].lvl0}};
      CMP_OUT_I <= {2{rows[r].lvl0}};
      wr(OFS_EDGE_SEL, {4{rows[r].mode}});
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_MF_FLAGS, 8'h00);
      wr(OFS_ENABLES, {2'h0, en[5:0]});
      wr(OFS_MF_EN, {2'h0, en[11:6]});
      wr(OFS_CTRL, 8'h01);
      if (rows[r].idx < 4)
        EXT_PIN_I[rows[r].idx[1:0]] <= rows[r].lvl1;
      else if (rows[r].idx < 6)
        CMP_OUT_I[rows[r].idx[0]] <= rows[r].lvl1;
      else
        MF_SUB_REQ_I <= en[11:6];
      @(posedge CLOCK_I);
      MF_SUB_REQ_I <= '0;
      wait_irq(rows[r].fire, rows[r].idx);
      rd(OFS_FLAGS, 8'h00);
      rd(OFS_MF_FLAGS, 8'h00);
      if (rows[r].fire)
        do_ret();
      wr(OFS_CTRL, 8'h00);
    end
    // Timer-3 register layout and its path into shared interrupt 3
    wr(OFS_T3_CTRL, 8'hFF);
    rd(OFS_T3_CTRL, 8'h33);
    wr(OFS_T3_CTRL, 8'h02);
    wr(OFS_MF_FLAGS, 8'h00);
    wr(OFS_MF_EN, 8'(1 << T3_MF_IDX));
    TMR3_CMPA_MATCH_I <= 1'h1;
    TMR3_CMPP_MATCH_I <= 1'h1;
    @(posedge CLOCK_I);
    TMR3_CMPA_MATCH_I <= 1'h0;
    TMR3_CMPP_MATCH_I <= 1'h0;
    wait_irq(1'h0, 4'h0);
    rd(OFS_T3_CTRL, 8'h32);
    chk("wake", WAKE_O, 1'h1);
    stall <= 1'h1;
    wr(OFS_CTRL, 8'h01);
    wait_irq(1'h0, 4'h0);
    stall <= 1'h0;
    wait_irq(1'h1, 4'(NUM_EXT + NUM_CMP + T3_MF_IDX));
    rd(OFS_T3_CTRL, 8'h32);
    rd(OFS_MF_FLAGS, 8'h00);
    do_ret();
    wr(OFS_T3_CTRL, 8'h00);
    // Priority between two pending sources and selective clearing
    wr(OFS_FLAGS, 8'h14);
    wr(OFS_ENABLES, 8'h00);
    wr(OFS_CTRL, 8'h01);
    wait_irq(1'h0, 4'h0);
    wr(OFS_ENABLES, 8'h14);
    wait_irq(1'h1, 4'h2);
    rd(OFS_FLAGS, 8'h10);
    do_ret();
    wr(OFS_CTRL, 8'h01);
    wait_irq(1'h1, 4'h4);
    do_ret();
    // Full stack holds off an enabled request until one pop
    wr(OFS_FLAGS, 8'h01);
    wr(OFS_ENABLES, 8'h01);
    repeat (DEPTH)
    begin
      @(posedge CLOCK_I);
      call <= 1'h1;
      @(posedge CLOCK_I);
      call <= 1'h0;
    end
    wr(OFS_CTRL, 8'h01);
    chk("full", STACK_FULL_O, 1'h1);
    rd(OFS_STATUS, 8'hC8);
    wait_irq(1'h0, 4'h0);
    @(posedge CLOCK_I);
    ret <= 1'h1;
    @(posedge CLOCK_I);
    ret <= 1'h0;
    wait_irq(1'h1, 4'h0);
    repeat (DEPTH)
    begin
      @(posedge CLOCK_I);
      ret <= 1'h1;
      @(posedge CLOCK_I);
      ret <= 1'h0;
      @(posedge CLOCK_I);
    end
    rd(OFS_STATUS, 8'h00);
    chk("idle_wake", WAKE_O, 1'h0);
    // Mid-run reset drops pending flags and the global enable
    wr(OFS_FLAGS, 8'h02);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CTRL, 8'h01);
    SYS_RST_I <= 1'h1;
    repeat (2) @(posedge CLOCK_I);
    SYS_RST_I <= 1'h0;
    @(posedge CLOCK_I);
    #1;
    chk("rst_gie", GLOBAL_IRQ_EN_O, 1'h0);
    chk("rst_wake", WAKE_O, 1'h0);
    rd(OFS_FLAGS, 8'h00);
    print_verdict();
  end
endmodule
